// ==== src/urx_top.sv ====
// apb register file, divisor staging and receive fifo of the receive block
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "urx_params.svh"
module urx_top import urx_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd
);
  // software registers
  logic [7:0] lcr_r, lcr_nxt;
  logic [15:0] idiv_r, idiv_nxt;
  logic [5:0] fdiv_r, fdiv_nxt;
  logic ovs_r, ovs_nxt;
  // divisor set used by the line
  logic [15:0] int_act_r, int_act_nxt;
  logic [5:0] frac_act_r, frac_act_nxt;
  logic ovs_act_r, ovs_act_nxt;
  // bus answer
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  // input synchroniser
  logic rxd_s1_r, rxd_s2_r;
  // fifo
  logic [9:0] mem_r [0:15];
  logic [3:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic ovr_r, ovr_nxt;
  logic [4:0] depth;
  logic push, pop, setup, acc;
  // receiver hookup
  logic tick, rx_done, rx_ferr, rx_perr, rx_busy;
  logic [7:0] rx_data;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser on the serial line, idles high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
    end else begin
      rxd_s1_r <= rxd;
      rxd_s2_r <= rxd_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tick generator on the staged divisor
  urx_baud u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .div_int(int_act_r),
    .div_frac(frac_act_r),
    .tick(tick)
  );

  // frame engine
  urx_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .rxd(rxd_s2_r),
    .os_sel(ovs_act_r),
    .pen(lcr_r[`URX_LCR_PEN]),
    .eps(lcr_r[`URX_LCR_EPS]),
    .sps(lcr_r[`URX_LCR_SPS]),
    .stp2(lcr_r[`URX_LCR_STP2]),
    .wlen(lcr_r[`URX_LCR_WLEN_LO +: 2]),
    .done(rx_done),
    .data(rx_data),
    .ferr(rx_ferr),
    .perr(rx_perr),
    .busy(rx_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb phases: answer one cycle after setup
  assign setup = psel && !penable;
  assign acc = psel && penable && pready_r;

  // register writes and divisor staging
  always_comb begin
    lcr_nxt = lcr_r;
    idiv_nxt = idiv_r;
    fdiv_nxt = fdiv_r;
    ovs_nxt = ovs_r;
    int_act_nxt = int_act_r;
    frac_act_nxt = frac_act_r;
    ovs_act_nxt = ovs_act_r;
    if (acc && pwrite) begin
      case (paddr)
        `URX_OFF_LCR: lcr_nxt = pwdata[7:0];
        `URX_OFF_IDIV: idiv_nxt = pwdata[15:0];
        `URX_OFF_FDIV: fdiv_nxt = pwdata[5:0];
        `URX_OFF_CTRL: ovs_nxt = pwdata[0];
        default: begin
        end
      endcase
    end
    // staged values move only between characters
    if (!rx_busy) begin
      int_act_nxt = idiv_r;
      frac_act_nxt = fdiv_r;
      ovs_act_nxt = ovs_r;
    end
  end

  // read mux and answer
  always_comb begin
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt = setup;
    if (setup) begin
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        `URX_OFF_DATA: begin
          if (cnt_r != 5'h00) begin
            prdata_nxt[9:0] = mem_r[rp_r];
          end
        end
        `URX_OFF_LCR: prdata_nxt[7:0] = lcr_r;
        `URX_OFF_IDIV: prdata_nxt[15:0] = idiv_r;
        `URX_OFF_FDIV: prdata_nxt[5:0] = fdiv_r;
        `URX_OFF_CTRL: prdata_nxt[0] = ovs_r;
        `URX_OFF_STAT: prdata_nxt[3:0] = {ovr_r, rx_busy, cnt_r == depth, cnt_r == 5'h00};
        default: pslverr_nxt = 1'b1;
      endcase
    end
  end

  // bus and configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcr_r <= `URX_LCR_RST;
      idiv_r <= `URX_IDIV_RST;
      fdiv_r <= `URX_FDIV_RST;
      ovs_r <= `URX_CTRL_RST;
      int_act_r <= `URX_IDIV_RST;
      frac_act_r <= `URX_FDIV_RST;
      ovs_act_r <= `URX_CTRL_RST;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      lcr_r <= lcr_nxt;
      idiv_r <= idiv_nxt;
      fdiv_r <= fdiv_nxt;
      ovs_r <= ovs_nxt;
      int_act_r <= int_act_nxt;
      frac_act_r <= frac_act_nxt;
      ovs_act_r <= ovs_act_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // fifo depth: full buffer or one holding slot
  assign depth = lcr_r[`URX_LCR_FEN] ? `URX_FIFO_DEPTH : `URX_FIFO_ONE;
  assign push = rx_done && cnt_r < depth;
  assign pop = acc && !pwrite && paddr == `URX_OFF_DATA && cnt_r != 5'h00;

  // pointers, count and overrun flag
  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    ovr_nxt = ovr_r;
    if (push) begin
      wp_nxt = wp_r + 4'h1;
    end
    if (pop) begin
      rp_nxt = rp_r + 4'h1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 5'h01;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 5'h01;
    end
    // status read clears, a new drop in that cycle wins
    if (acc && !pwrite && paddr == `URX_OFF_STAT) begin
      ovr_nxt = 1'b0;
    end
    if (rx_done && !push) begin
      ovr_nxt = 1'b1;
    end
  end

  // fifo control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r <= 4'h0;
      rp_r <= 4'h0;
      cnt_r <= 5'h00;
      ovr_r <= 1'b0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      ovr_r <= ovr_nxt;
    end
  end

  // character storage with its error marks
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_r[wp_r] <= {rx_perr, rx_ferr, rx_data};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_div_hold;
    rx_busy ##1 rx_busy |-> $stable(int_act_r) && $stable(frac_act_r) && $stable(ovs_act_r);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divisor moved mid frame");
  property p_div_take;
    !rx_busy |=> int_act_r == $past(idiv_r) && ovs_act_r == $past(ovs_r);
  endproperty
  a_div_take: assert property (p_div_take) else $error("divisor not staged");
  property p_single;
    !lcr_r[`URX_LCR_FEN] && cnt_r == 5'h01 && rx_done && !pop |=> cnt_r == 5'h01 && ovr_r;
  endproperty
  a_single: assert property (p_single) else $error("holding slot overfilled");
  property p_ready;
    setup |=> pready_r ##1 !pready_r;
  endproperty
  a_ready: assert property (p_ready) else $error("apb answer timing");
  c_push_full: cover property (push && cnt_r == 5'h0f);
  c_err_char: cover property (push && (rx_perr || rx_ferr));
  c_stage: cover property (rx_busy ##1 !rx_busy && idiv_r != int_act_r);
endmodule

// ==== src/urx_params.svh ====
// register map, field positions and reset values of the receive format block
`ifndef URX_PARAMS_SVH
`define URX_PARAMS_SVH
`define URX_OFF_DATA 12'h000
`define URX_OFF_LCR 12'h01c
`define URX_OFF_IDIV 12'h024
`define URX_OFF_FDIV 12'h028
`define URX_OFF_CTRL 12'h030
`define URX_OFF_STAT 12'h034
`define URX_LCR_PEN 1
`define URX_LCR_EPS 2
`define URX_LCR_STP2 3
`define URX_LCR_FEN 4
`define URX_LCR_WLEN_LO 5
`define URX_LCR_SPS 7
`define URX_LCR_RST 8'h00
`define URX_IDIV_RST 16'h0000
`define URX_FDIV_RST 6'h00
`define URX_CTRL_RST 1'h0
`define URX_OS16 5'h10
`define URX_OS8 5'h08
`define URX_WLEN_BASE 4'h5
`define URX_FIFO_DEPTH 5'h10
`define URX_FIFO_ONE 5'h01
`endif

// ==== src/urx_pkg.sv ====
// types shared by the receive format block
package urx_pkg;
  typedef enum logic [4:0] {
    urx_idle = 5'h01,
    urx_start = 5'h02,
    urx_data = 5'h04,
    urx_par = 5'h08,
    urx_stop = 5'h10
  } urx_state_t;
endpackage

// ==== src/urx_baud.sv ====
// oversampling tick generator from integer and fractional divisor
`timescale 1ns/1ps
`include "urx_params.svh"
module urx_baud import urx_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] div_int,
  input wire logic [5:0] div_frac,
  output logic tick
);
  logic [15:0] cnt_r, cnt_nxt;
  logic [5:0] acc_r, acc_nxt;
  logic tick_r, tick_nxt;
  logic [6:0] sum;

  // tick every div_int cycles, one extra on fraction carry
  always_comb begin
    sum = {1'b0, acc_r} + {1'b0, div_frac};
    cnt_nxt = cnt_r;
    acc_nxt = acc_r;
    tick_nxt = 1'b0;
    if (div_int == `URX_IDIV_RST) begin
      cnt_nxt = 16'h0000;
    end else if (cnt_r == 16'h0000 || cnt_r > div_int) begin // stale long count restarts
      tick_nxt = 1'b1;
      acc_nxt = sum[5:0];
      cnt_nxt = div_int - 16'h0001 + {15'h0000, sum[6]};
    end else begin
      cnt_nxt = cnt_r - 16'h0001;
    end
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      acc_r <= 6'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      acc_r <= acc_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign tick = tick_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_tick_gap;
    tick_r && div_int == 16'h0002 && div_frac == 6'h00 && $stable(div_int) && $stable(div_frac)
      |=> !tick_r ##1 tick_r;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");
endmodule

// ==== src/urx_rx.sv ====
// receive frame engine: start, data, parity and stop bit checking
`timescale 1ns/1ps
`include "urx_params.svh"
module urx_rx import urx_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic rxd,
  input wire logic os_sel,
  input wire logic pen,
  input wire logic eps,
  input wire logic sps,
  input wire logic stp2,
  input wire logic [1:0] wlen,
  output logic done,
  output logic [7:0] data,
  output logic ferr,
  output logic perr,
  output logic busy
);
  urx_state_t fsm_r, fsm_nxt;
  logic [4:0] tcnt_r, tcnt_nxt;
  logic [3:0] bcnt_r, bcnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic ferr_r, ferr_nxt, perr_r, perr_nxt, done_r, done_nxt;
  logic [4:0] os;
  logic [3:0] nbits;
  logic bit_end, par_exp, hold_low;

  // oversampling factor and word length decode
  assign os = os_sel ? `URX_OS8 : `URX_OS16;
  assign nbits = `URX_WLEN_BASE + {2'b00, wlen};
  assign bit_end = tick && tcnt_r == os - 5'h01;
  // parked after a low stop bit until the line rises
  assign hold_low = bcnt_r == 4'h2;
  // stick gives inverse of even select, else odd/even sum of data
  assign par_exp = sps ? ~eps : (eps ? ^sh_r : ~^sh_r);

  // frame sequencing
  always_comb begin
    fsm_nxt = fsm_r;
    tcnt_nxt = tcnt_r;
    bcnt_nxt = bcnt_r;
    sh_nxt = sh_r;
    ferr_nxt = ferr_r;
    perr_nxt = perr_r;
    done_nxt = 1'b0;
    case (fsm_r)
      urx_idle: begin
        if (tick && !rxd) begin
          fsm_nxt = urx_start;
          tcnt_nxt = 5'h01;
        end
      end
      urx_start: begin
        if (tick) begin
          tcnt_nxt = tcnt_r + 5'h01;
          if (tcnt_r == (os >> 1) - 5'h01) begin
            tcnt_nxt = 5'h00;
            bcnt_nxt = 4'h0;
            sh_nxt = 8'h00;
            ferr_nxt = 1'b0;
            perr_nxt = 1'b0;
            fsm_nxt = rxd ? urx_idle : urx_data;
          end
        end
      end
      urx_data: begin
        if (tick) begin
          tcnt_nxt = tcnt_r + 5'h01;
        end
        if (bit_end) begin
          tcnt_nxt = 5'h00;
          sh_nxt[bcnt_r[2:0]] = rxd;
          bcnt_nxt = bcnt_r + 4'h1;
          if (bcnt_r == nbits - 4'h1) begin
            bcnt_nxt = 4'h0;
            fsm_nxt = pen ? urx_par : urx_stop;
          end
        end
      end
      urx_par: begin
        if (tick) begin
          tcnt_nxt = tcnt_r + 5'h01;
        end
        if (bit_end) begin
          tcnt_nxt = 5'h00;
          perr_nxt = rxd != par_exp;
          fsm_nxt = urx_stop;
        end
      end
      urx_stop: begin
        if (tick) begin
          tcnt_nxt = tcnt_r + 5'h01;
        end
        if (hold_low) begin
          // a low line here is not a new start bit
          tcnt_nxt = 5'h00;
          if (rxd) begin
            fsm_nxt = urx_idle;
          end
        end else if (bit_end) begin
          tcnt_nxt = 5'h00;
          if (!rxd) begin
            ferr_nxt = 1'b1;
          end
          if (stp2 && bcnt_r == 4'h0) begin
            bcnt_nxt = 4'h1;
          end else begin
            done_nxt = 1'b1;
            fsm_nxt = urx_idle;
            if (!rxd) begin
              fsm_nxt = urx_stop;
              bcnt_nxt = 4'h2;
            end
          end
        end
      end
      default: begin
        fsm_nxt = urx_idle;
      end
    endcase
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsm_r <= urx_idle;
      tcnt_r <= 5'h00;
      bcnt_r <= 4'h0;
      sh_r <= 8'h00;
      ferr_r <= 1'b0;
      perr_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      fsm_r <= fsm_nxt;
      tcnt_r <= tcnt_nxt;
      bcnt_r <= bcnt_nxt;
      sh_r <= sh_nxt;
      ferr_r <= ferr_nxt;
      perr_r <= perr_nxt;
      done_r <= done_nxt;
    end
  end
  assign done = done_r;
  assign data = sh_r;
  assign ferr = ferr_r;
  assign perr = perr_r;
  assign busy = fsm_r != urx_idle;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_no_par;
    fsm_r == urx_data && bit_end && bcnt_r == nbits - 4'h1 && !pen |=> fsm_r == urx_stop;
  endproperty
  a_no_par: assert property (p_no_par) else $error("parity slot taken");
  property p_odd;
    fsm_r == urx_par && bit_end && !sps && !eps && !(^{sh_r, rxd}) |=> perr_r;
  endproperty
  a_odd: assert property (p_odd) else $error("odd parity miss");
  property p_even;
    fsm_r == urx_par && bit_end && !sps && eps && (^{sh_r, rxd}) |=> perr_r;
  endproperty
  a_even: assert property (p_even) else $error("even parity miss");
  property p_stick;
    fsm_r == urx_par && bit_end && sps && rxd == eps |=> perr_r;
  endproperty
  a_stick: assert property (p_stick) else $error("stick parity miss");
  property p_two_stop;
    fsm_r == urx_stop && bit_end && stp2 && bcnt_r == 4'h0 |=> fsm_r == urx_stop && !done_r;
  endproperty
  a_two_stop: assert property (p_two_stop) else $error("second stop skipped");
  property p_wlen;
    fsm_r == urx_data |-> bcnt_r < nbits;
  endproperty
  a_wlen: assert property (p_wlen) else $error("too many data bits");
  property p_os;
    fsm_r != urx_idle |-> tcnt_r < os;
  endproperty
  a_os: assert property (p_os) else $error("oversample count high");
  property p_ferr;
    fsm_r == urx_stop && bit_end && !rxd |=> ferr_r;
  endproperty
  a_ferr: assert property (p_ferr) else $error("framing error lost");
endmodule

// ==== verif/urx_tx_model.sv ====
// serial transmitter model driving the receive line
`timescale 1ns/1ps
module urx_tx_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic [15:0] bit_cycles,
  input wire logic [1:0] wlen,
  input wire logic [7:0] data,
  input wire logic pen,
  input wire logic eps,
  input wire logic sps,
  input wire logic stp2,
  input wire logic bad_par,
  input wire logic bad_stop,
  output logic rxd,
  output logic busy
);
  logic p;
  logic [7:0] m;
  ////////////////////////////////////////////////////////////////
  // one bit held for a full bit time
  task automatic send(input logic b);
    rxd <= b;
    repeat (bit_cycles) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////
  // one frame per go pulse, lsb first, line idles high
  initial begin
    rxd = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge pclk);
      if (go) begin
        busy <= 1'b1;
        m = data & (8'hff >> (3 - wlen));
        p = sps ? !eps : !(eps ^ (^m));
        send(1'b0);
        for (int i = 0; i < 5 + wlen; i++) send(m[i]);
        if (pen) send(p ^ bad_par);
        if (stp2) send(1'b1);
        send(!bad_stop);
        rxd <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule

// ==== verif/urx_top_tb_top.sv ====
// self-checking bench of the receive format block
`timescale 1ns/1ps
module urx_top_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, go, busy, e;
  logic pe, ep, sp, s2, bp, bs, os;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] bc;
  logic [7:0] td;
  logic [7:0] qd[$];
  logic [1:0] wl;
  int n_mismatch, tests_run;

  urx_top i_urx_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd));
  urx_tx_model i_urx_tx_model (.pclk(pclk), .go(go), .bit_cycles(bc), .wlen(wl),
    .data(td), .pen(pe), .eps(ep), .sps(sp), .stp2(s2), .bad_par(bp), .bad_stop(bs),
    .rxd(rxd), .busy(busy));

  // clock
  always #25 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
      n_mismatch++;
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_mismatch++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    chk("prdata", q, exp);
    chk("pslverr", {31'h0, e}, {31'h0, err});
  endtask
  // line format, oversampling and divisor while the receiver is idle
  task automatic cfg(input logic fen, input logic [15:0] ib);
    wr(12'h01c, {24'h0, sp, wl, fen, s2, ep, pe, 1'b0});
    wr(12'h030, {31'h0, os});
    wr(12'h024, {16'h0, ib});
    bc = (os ? 16'h0008 : 16'h0010) * ib;
  endtask
  task automatic kick();
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic fin();
    while (busy === 1'b1) @(posedge pclk);
    repeat (4) @(posedge pclk);
  endtask
  // expected data register word for the frame just sent
  function automatic logic [31:0] expd();
    return {22'h0, pe & bp, bs, td & (8'hff >> (3 - wl))};
  endfunction
  task automatic results();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (90000) @(posedge pclk);
    n_mismatch++;
    results();
  end
  // main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    go = 0; td = 0; wl = 3; pe = 0; ep = 0; sp = 0; s2 = 0; bp = 0; bs = 0; os = 0;
    bc = 16'h0020;
    n_mismatch = 0;
    tests_run = 0;
    void'($urandom(75409));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, decoding and field widths
    rd(12'h01c, 32'h0, 1'b0);
    rd(12'h024, 32'h0, 1'b0);
    rd(12'h028, 32'h0, 1'b0);
    rd(12'h030, 32'h0, 1'b0);
    rd(12'h034, 32'h1, 1'b0);
    rd(12'h040, 32'h0, 1'b1);
    wr(12'h024, 32'hffffffff);
    rd(12'h024, 32'h0000ffff, 1'b0);
    wr(12'h028, 32'hffffffff);
    rd(12'h028, 32'h0000003f, 1'b0);
    wr(12'h01c, 32'h000000fe);
    rd(12'h01c, 32'h000000fe, 1'b0);
    wr(12'h028, 32'h0);
    // random formats with injected parity and stop faults
    repeat (24) begin
      {wl, pe, ep, sp, s2, os} = 7'($urandom);
      bp = ($urandom % 4) == 0;
      bs = ($urandom % 4) == 0;
      td = 8'($urandom);
      cfg(1'b1, 16'(2 + $urandom % 3));
      kick();
      fin();
      rd(12'h000, expd(), 1'b0);
    end
    // divisor written mid character applies to the next one
    {wl, pe, s2, bp, bs, os} = 7'h60;
    cfg(1'b1, 16'h0003);
    td = 8'ha5;
    kick();
    repeat (100) @(posedge pclk);
    wr(12'h024, 32'h2);
    fin();
    rd(12'h000, expd(), 1'b0);
    bc = 16'h0020;
    td = 8'h3c;
    kick();
    fin();
    rd(12'h000, expd(), 1'b0);
    // single character mode then buffered, each overfilled by one
    for (int f = 0; f < 2; f++) begin
      cfg(f[0], 16'h0002);
      for (int k = 0; k <= (f ? 16 : 1); k++) begin
        td = 8'($urandom);
        kick();
        fin();
        if (k < (f ? 16 : 1)) qd.push_back(td);
      end
      rd(12'h034, 32'ha, 1'b0);
      rd(12'h034, 32'h2, 1'b0);
      while (qd.size() > 0) rd(12'h000, {24'h0, qd.pop_front()}, 1'b0);
      rd(12'h034, 32'h1, 1'b0);
    end
    results();
  end
endmodule
